// *** pdf_fault_cmd_regs.sv ***
/*
  pdf_fault_cmd_regs: fault flag register and low command decoder of a
  power delivery port phy, plus the presence detect and sinking status bits.
  Assumes an external serial slave turns bus transactions into one-cycle
  byte read and write strobes on this clock; analog comparator outputs
  arrive asynchronously; power control levels come from the same clock.
*/
// How it works
// [R1] fault register at 0x1f, eight bits, cleared to zero on reset.
// [R2] bit 7 reserved: always reads zero, writes to it ignored.
// [R3] auto discharge armed and vbus not low in time latches bit 5.
// [R4] forced discharge armed and vbus not low in time latches bit 4.
// [R5] cable supply overcurrent, or supply lost with switch closed, latches bit 1.
// [R6] transmit request with an empty outgoing buffer latches bit 0.
// [R7] bits 6, 3 and 2 are unsupported faults and always read zero.
// [R8] command register at 0x23, writable, resets zero, each byte one opcode.
// [R9] wake opcode is stored but causes no action.
// [R10] presence detect off opcode turns vbus presence detection off.
// [R11] presence detect on opcode turns vbus presence detection on.
// [R12] stop sinking opcode clears the sinking flag.
// [R13] presence monitor status follows the presence detection state.
// [R14] sinking flag is one while sinking vbus, otherwise zero.
// [R15] writing one to a fault bit clears it; zero leaves it.
// [R16] unknown opcodes are stored with no other effect.
`timescale 1ns/1ps
`default_nettype none
module pdf_fault_cmd_regs
  import pdf_pkg::*;
#(
  parameter logic [pdf_pkg::PDF_TMO_CW-1:0] TSAFE0V_US = 32'd650000
) (
  input  wire logic       clk,                          // 250 MHz clock
  input  wire logic       rst_n,                        // async reset
  input  wire logic [7:0] reg_addr,                     // register address
  input  wire logic [7:0] reg_wdata,                    // write byte
  input  wire logic       reg_wr,                       // write strobe, 1 cycle
  input  wire logic       reg_rd,                       // read strobe, 1 cycle
  output logic      [7:0] reg_rdata,                    // read byte, registered
  output logic            reg_rvalid,                   // read data valid pulse
  input  wire logic       vbus_low_pin,                 // vbus below safe-zero, async
  input  wire logic       cable_ocp_pin,                // cable supply overcurrent, async
  input  wire logic       cable_present_pin,            // cable supply above threshold
  input  wire logic       cable_switch_closed,          // cable supply switch closed
  input  wire logic       auto_discharge_on_disconnect, // power control bit
  input  wire logic       auto_discharge_active,        // auto discharge running
  input  wire logic       force_discharge_enable,       // power control bit
  input  wire logic       tx_request,                   // transmit issued, pulse
  input  wire logic       tx_buffer_empty,              // outgoing buffer empty
  input  wire logic       sink_start,                   // start sinking, pulse
  output logic            presence_monitor_active,      // detection on, power status bit 3
  output logic            sinking_flag,                 // sinking vbus, power status bit 0
  output logic            presence_detect_enable        // drives detection circuit
);

  import pdf_pkg::*;

  // two-flop synchronisers for the comparator pins
  logic [PDF_NUM_PINS-1:0] pin_raw;
  logic [PDF_NUM_PINS-1:0] pin_meta_reg;
  logic [PDF_NUM_PINS-1:0] pin_sync_reg;

  assign pin_raw[PDF_PIN_VBUS_LOW]   = vbus_low_pin;
  assign pin_raw[PDF_PIN_CABLE_OCP]  = cable_ocp_pin;
  assign pin_raw[PDF_PIN_CABLE_PRES] = cable_present_pin;

  genvar gi;
  generate
    for (gi = 0; gi < PDF_NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic vbus_low;
  logic cable_ocp;
  logic cable_present;

  assign vbus_low      = pin_sync_reg[PDF_PIN_VBUS_LOW];
  assign cable_ocp     = pin_sync_reg[PDF_PIN_CABLE_OCP];
  assign cable_present = pin_sync_reg[PDF_PIN_CABLE_PRES];

  // microsecond tick divider; keeps the timeout counters narrow
  logic [PDF_TICK_CW-1:0] tick_cnt_reg;
  logic                   tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign tick = (tick_cnt_reg == PDF_TICK_LAST);

  // discharge watchdogs, one per discharge source
  logic auto_dis_fail;
  logic forced_dis_fail;
  logic auto_arm;

  // auto discharge only counts when the option is enabled
  assign auto_arm = auto_discharge_on_disconnect && auto_discharge_active;

  pdf_discharge_timer #(
    .LIMIT_TICKS (TSAFE0V_US)
  ) u_auto_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .arm        (auto_arm),
    .vbus_low   (vbus_low),
    .fail_pulse (auto_dis_fail)   // [R3]
  );

  pdf_discharge_timer #(
    .LIMIT_TICKS (TSAFE0V_US)
  ) u_forced_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .tick       (tick),
    .arm        (force_discharge_enable),
    .vbus_low   (vbus_low),
    .fail_pulse (forced_dis_fail) // [R4]
  );

  // address decode of the access strobes
  logic wr_fault;
  logic wr_command;

  always_comb begin
    wr_fault   = 1'b0;
    wr_command = 1'b0;
    if (reg_wr && reg_addr == PDF_ADDR_FAULT) begin
      wr_fault = 1'b1;
    end else if (reg_wr && reg_addr == PDF_ADDR_COMMAND) begin
      wr_command = 1'b1;
    end
  end

  // fault events collected into their bit positions
  logic [7:0] fault_set;

  always_comb begin
    fault_set                    = 8'h00;
    fault_set[PDF_BIT_AUTO_DIS]   = auto_dis_fail;                                   // [R3]
    fault_set[PDF_BIT_FORCED_DIS] = forced_dis_fail;                                 // [R4]
    fault_set[PDF_BIT_CABLE_OCP]  = cable_ocp || (!cable_present && cable_switch_closed); // [R5]
    fault_set[PDF_BIT_EMPTY_TX]   = tx_request && tx_buffer_empty;                   // [R6]
  end

  // write-one-to-clear; a new event in the clearing cycle still sets
  logic [7:0] fault_clr;
  logic [7:0] fault_flags_reg;
  logic [7:0] fault_flags_next;

  assign fault_clr        = wr_fault ? reg_wdata : 8'h00;                 // [R15]
  assign fault_flags_next = ((fault_flags_reg & ~fault_clr) | fault_set)
                            & PDF_FAULT_IMPL_MASK;                        // [R2] [R7]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flags_reg <= PDF_FAULT_RST;                                   // [R1]
    end else begin
      fault_flags_reg <= fault_flags_next;
    end
  end

  // command byte is kept for readback, every write accepted
  logic [7:0] command_code_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_code_reg <= PDF_COMMAND_RST;                                // [R8]
    end else if (wr_command) begin
      command_code_reg <= reg_wdata;                                      // [R8]
    end
  end

  // opcode decode; the written byte acts in the cycle of the write
  logic op_det_off;
  logic op_det_on;
  logic op_stop_sink;

  always_comb begin
    op_det_off   = 1'b0;
    op_det_on    = 1'b0;
    op_stop_sink = 1'b0;
    if (wr_command) begin
      case (reg_wdata)
        PDF_OP_WAKE_NOOP:    ;                                            // [R9]
        PDF_OP_PRES_DET_OFF: op_det_off   = 1'b1;                         // [R10]
        PDF_OP_PRES_DET_ON:  op_det_on    = 1'b1;                         // [R11]
        PDF_OP_STOP_SINKING: op_stop_sink = 1'b1;                         // [R12]
        default:             ;                                            // [R16]
      endcase
    end
  end

  // presence detection state, mirrored into the power status bit
  logic presence_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presence_reg <= 1'b0;
    end else if (op_det_on) begin
      presence_reg <= 1'b1;                                               // [R11]
    end else if (op_det_off) begin
      presence_reg <= 1'b0;                                               // [R10]
    end
  end

  assign presence_detect_enable  = presence_reg;
  assign presence_monitor_active = presence_reg;                          // [R13]

  // sinking status; a start in the same cycle as stop wins
  logic sinking_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinking_reg <= 1'b0;
    end else if (sink_start) begin
      sinking_reg <= 1'b1;                                                // [R14]
    end else if (op_stop_sink) begin
      sinking_reg <= 1'b0;                                                // [R12]
    end
  end

  assign sinking_flag = sinking_reg;                                      // [R14]

  // registered read path; unmapped addresses read zero
  logic [7:0] rd_mux;

  always_comb begin
    if (reg_addr == PDF_ADDR_FAULT) begin
      rd_mux = fault_flags_reg;                                           // [R2] [R7]
    end else if (reg_addr == PDF_ADDR_COMMAND) begin
      rd_mux = command_code_reg;
    end else begin
      rd_mux = PDF_RDATA_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= PDF_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

endmodule
`default_nettype wire

// *** pdf_pkg.sv ***
/*
  pdf_pkg: shared constants for the fault flag and command register bank.
  Assumes a 250 MHz system clock and a byte-wide register access port.
*/
package pdf_pkg;

  // register map
  localparam logic [7:0] PDF_ADDR_FAULT   = 8'h1f;
  localparam logic [7:0] PDF_ADDR_COMMAND = 8'h23;

  // reset values
  localparam logic [7:0] PDF_FAULT_RST    = 8'h00;
  localparam logic [7:0] PDF_COMMAND_RST  = 8'h00;
  localparam logic [7:0] PDF_RDATA_RST    = 8'h00;

  // fault flag bit positions
  localparam int PDF_BIT_RESERVED     = 7;
  localparam int PDF_BIT_FORCED_OFF   = 6;
  localparam int PDF_BIT_AUTO_DIS     = 5;
  localparam int PDF_BIT_FORCED_DIS   = 4;
  localparam int PDF_BIT_BUS_OCP      = 3;
  localparam int PDF_BIT_BUS_OVP      = 2;
  localparam int PDF_BIT_CABLE_OCP    = 1;
  localparam int PDF_BIT_EMPTY_TX     = 0;

  // bits that can ever be set; all others read zero
  localparam logic [7:0] PDF_FAULT_IMPL_MASK = 8'h33;

  // command opcodes decoded here
  localparam logic [7:0] PDF_OP_WAKE_NOOP     = 8'h11;
  localparam logic [7:0] PDF_OP_PRES_DET_OFF  = 8'h22;
  localparam logic [7:0] PDF_OP_PRES_DET_ON   = 8'h33;
  localparam logic [7:0] PDF_OP_STOP_SINKING  = 8'h44;

  // timing: clock period and the microsecond tick
  localparam int PDF_CLK_PERIOD_PS = 4000;
  localparam int PDF_TICK_PS       = 1000000;
  localparam int PDF_TICK_CYCLES   = PDF_TICK_PS / PDF_CLK_PERIOD_PS;
  localparam int PDF_TICK_CW       = 8;
  localparam logic [PDF_TICK_CW-1:0] PDF_TICK_LAST = PDF_TICK_CW'(PDF_TICK_CYCLES - 1);

  // discharge timeout counter width (in microsecond ticks)
  localparam int PDF_TMO_CW = 32;

  // number of asynchronous pin inputs passed through synchronisers
  localparam int PDF_NUM_PINS = 3;
  localparam int PDF_PIN_VBUS_LOW   = 0;
  localparam int PDF_PIN_CABLE_OCP  = 1;
  localparam int PDF_PIN_CABLE_PRES = 2;

endpackage

// *** pdf_discharge_timer.sv ***
/*
  pdf_discharge_timer: watches one discharge request and pulses a failure
  when vbus has not reached the safe-zero level within the allowed time.
  Assumes tick is a one-cycle enable from a divider on the same clock and
  vbus_low is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module pdf_discharge_timer
  import pdf_pkg::*;
#(
  parameter logic [pdf_pkg::PDF_TMO_CW-1:0] LIMIT_TICKS = 32'd650000
) (
  input  wire logic clk,        // system clock
  input  wire logic rst_n,      // async reset, active low
  input  wire logic tick,       // microsecond enable pulse
  input  wire logic arm,        // discharge requested, level
  input  wire logic vbus_low,   // vbus below safe-zero, synchronised
  output logic      fail_pulse  // one cycle on timeout
);

  logic [PDF_TMO_CW-1:0] count_reg;
  logic                  done_reg;

  // count while armed and vbus still high; reset whenever disarmed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!arm || done_reg) begin
      count_reg <= '0;
    end else if (tick && !vbus_low) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // one verdict per request: success or failure ends the watch until rearm
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (!arm) begin
      done_reg <= 1'b0;
    end else if (vbus_low || fail_pulse) begin
      done_reg <= 1'b1;
    end
  end

  // failure once the full window elapsed without vbus falling
  assign fail_pulse = arm && !done_reg && !vbus_low && (count_reg >= LIMIT_TICKS);

endmodule
`default_nettype wire

// *** pdf_fault_cmd_regs_properties.sv ***
/*
  pdf_fault_cmd_regs_chk: port assertions for the fault and command bank.
  Assumes the one-cycle byte strobe port and the same-clock event inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module pdf_fault_cmd_regs_chk
  import pdf_pkg::*;
(
  input wire logic       clk,                     // clock
  input wire logic       rst_n,                   // reset
  input wire logic [7:0] reg_addr,                // address
  input wire logic [7:0] reg_wdata,               // write byte
  input wire logic       reg_wr,                  // write strobe
  input wire logic       reg_rd,                  // read strobe
  input wire logic [7:0] reg_rdata,               // read byte
  input wire logic       reg_rvalid,              // read valid
  input wire logic       tx_request,              // transmit pulse
  input wire logic       tx_buffer_empty,         // buffer empty
  input wire logic       sink_start,              // sink pulse
  input wire logic       presence_monitor_active, // detection status
  input wire logic       sinking_flag,            // sinking status
  input wire logic       presence_detect_enable   // detection drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic cmd_wr;
  // a write to the command register this cycle
  assign cmd_wr = reg_wr && reg_addr == PDF_ADDR_COMMAND;

  property p_read_answer; reg_rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_zero_bits;
    $past(reg_rd) && $past(reg_addr) == PDF_ADDR_FAULT |->
      reg_rvalid && (reg_rdata & ~PDF_FAULT_IMPL_MASK) == 8'h00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("fault spare bit set");
  // flag must be readable three cycles on unless cleared in between
  property p_empty_tx;
    (tx_request && tx_buffer_empty) ##1 !reg_wr ##1 !reg_wr
      ##1 (reg_rd && reg_addr == PDF_ADDR_FAULT) |=> reg_rdata[0];
  endproperty
  a_empty_tx: assert property (p_empty_tx) else $error("empty transmit lost");
  property p_det_on; cmd_wr && reg_wdata == PDF_OP_PRES_DET_ON |=> presence_monitor_active;
  endproperty
  a_det_on: assert property (p_det_on) else $error("detection not on");
  property p_det_off; cmd_wr && reg_wdata == PDF_OP_PRES_DET_OFF |=> !presence_monitor_active;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detection not off");
  property p_stop_sink;
    cmd_wr && reg_wdata == PDF_OP_STOP_SINKING && !sink_start |=> !sinking_flag;
  endproperty
  a_stop_sink: assert property (p_stop_sink) else $error("sinking not cleared");
  property p_sink_set; sink_start |=> sinking_flag; endproperty
  a_sink_set: assert property (p_sink_set) else $error("sinking not set");
  property p_mirror; presence_monitor_active == presence_detect_enable; endproperty
  a_mirror: assert property (p_mirror) else $error("status and drive differ");
  property p_other_ops;
    !(cmd_wr && (reg_wdata == PDF_OP_PRES_DET_ON || reg_wdata == PDF_OP_PRES_DET_OFF))
      |=> $stable(presence_monitor_active);
  endproperty
  a_other_ops: assert property (p_other_ops) else $error("detection moved");
  c_det_on: cover property (cmd_wr && reg_wdata == PDF_OP_PRES_DET_ON);
  c_tx: cover property (tx_request && tx_buffer_empty);
  c_stop: cover property (cmd_wr && reg_wdata == PDF_OP_STOP_SINKING && sinking_flag);
endmodule
bind pdf_fault_cmd_regs pdf_fault_cmd_regs_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .tx_request, .tx_buffer_empty, .sink_start,
  .presence_monitor_active, .sinking_flag, .presence_detect_enable);
`default_nettype wire

// *** pdf_port_mgr.sv ***
/*
  pdf_port_mgr: port manager model issuing byte reads and writes.
  Assumes the strobe port answers a read within four cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pdf_port_mgr
  import pdf_pkg::*;
(
  input  wire logic       clk,        // clock
  output var  logic [7:0] reg_addr,   // address
  output var  logic [7:0] reg_wdata,  // write byte
  output var  logic       reg_wr,     // write strobe
  output var  logic       reg_rd,     // read strobe
  input  wire logic [7:0] reg_rdata,  // read byte
  input  wire logic       reg_rvalid  // read valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // idle bus shows inverted values so nothing stale looks valid
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    d = 8'hxx;
    n = 0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (reg_rvalid === 1'b1) begin
      d = reg_rdata;
    end
  endtask
  // clear by writing ones, spare bit always sent as zero
  task automatic clear_flags(input logic [7:0] m);
    write_byte(PDF_ADDR_FAULT, m & 8'h7f);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
  tb_top: self-checking bench for the fault and command register bank.
  Assumes the port manager model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pdf_pkg::*;
;
  localparam logic [31:0] TSAFE = 32'd3;
  localparam logic [4:0] EXP_PRES = 5'b00111;
  localparam logic [4:0] EXP_SINK = 5'b01111;
  logic [7:0] ops [5] = '{8'h33, 8'h11, 8'h05, 8'h22, 8'h44};
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, vbus_low_pin, cable_ocp_pin;
  logic cable_present_pin, cable_switch_closed, auto_discharge_on_disconnect;
  logic auto_discharge_active, force_discharge_enable, tx_request, tx_buffer_empty;
  logic sink_start, presence_monitor_active, sinking_flag, presence_detect_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int fail_count, num_checks;

  pdf_fault_cmd_regs #(.TSAFE0V_US(TSAFE)) u_pdf_fault_cmd_regs (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .vbus_low_pin, .cable_ocp_pin,
    .cable_present_pin, .cable_switch_closed, .auto_discharge_on_disconnect,
    .auto_discharge_active, .force_discharge_enable, .tx_request, .tx_buffer_empty,
    .sink_start, .presence_monitor_active, .sinking_flag, .presence_detect_enable);
  pdf_port_mgr u_pdf_port_mgr (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_pdf_port_mgr.read_byte(a, d);
    check(d, exp);
  endtask
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tx_pulse(input logic e);
    @(posedge clk);
    tx_request <= 1'b1;
    tx_buffer_empty <= e;
    @(posedge clk);
    tx_request <= 1'b0;
  endtask
  task automatic pins(input logic ocp, input logic pres, input logic sw);
    @(posedge clk);
    cable_ocp_pin <= ocp;
    cable_present_pin <= pres;
    cable_switch_closed <= sw;
    repeat (5) @(posedge clk);
  endtask
  // arm, wait past the timeout plus one tick and sync, then disarm
  task automatic dis_run(input logic f, input logic ao, input logic aa, input logic vl);
    @(posedge clk);
    force_discharge_enable <= f;
    auto_discharge_on_disconnect <= ao;
    auto_discharge_active <= aa;
    vbus_low_pin <= vl;
    repeat (1100) @(posedge clk);
    force_discharge_enable <= 1'b0;
    auto_discharge_active <= 1'b0;
  endtask
  task automatic t_tx_cable;
    tx_pulse(1'b0);
    rd_chk(PDF_ADDR_FAULT, 8'h00);
    tx_pulse(1'b1);
    rd_chk(PDF_ADDR_FAULT, 8'h01);
    u_pdf_port_mgr.write_byte(PDF_ADDR_FAULT, 8'h7e);
    rd_chk(PDF_ADDR_FAULT, 8'h01);
    u_pdf_port_mgr.clear_flags(8'h01);
    rd_chk(PDF_ADDR_FAULT, 8'h00);
    pins(1'b1, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    rd_chk(PDF_ADDR_FAULT, 8'h02);
    u_pdf_port_mgr.clear_flags(8'h02);
    rd_chk(PDF_ADDR_FAULT, 8'h00);
    pins(1'b0, 1'b0, 1'b1);
    rd_chk(PDF_ADDR_FAULT, 8'h02);
    pins(1'b0, 1'b1, 1'b0);
    u_pdf_port_mgr.clear_flags(8'h02);
  endtask
  task automatic t_cmds;
    @(posedge clk);
    sink_start <= 1'b1;
    @(posedge clk);
    sink_start <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      u_pdf_port_mgr.write_byte(PDF_ADDR_COMMAND, ops[i]);
      rd_chk(PDF_ADDR_COMMAND, ops[i]);
      check({6'h00, presence_monitor_active, sinking_flag},
            {6'h00, EXP_PRES[i], EXP_SINK[i]});
    end
    u_pdf_port_mgr.write_byte(8'h20, 8'h33);
    rd_chk(8'h20, 8'h00);
    rd_chk(PDF_ADDR_COMMAND, 8'h44);
  endtask
  task automatic t_discharge;
    dis_run(1'b0, 1'b0, 1'b1, 1'b0);
    rd_chk(PDF_ADDR_FAULT, 8'h00);
    dis_run(1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(PDF_ADDR_FAULT, 8'h10);
    u_pdf_port_mgr.clear_flags(8'h10);
    dis_run(1'b0, 1'b1, 1'b1, 1'b0);
    rd_chk(PDF_ADDR_FAULT, 8'h20);
    u_pdf_port_mgr.clear_flags(8'h20);
    dis_run(1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk(PDF_ADDR_FAULT, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // generous span: the discharge runs dominate at about 4500 cycles
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
  initial begin
    {rst_n, vbus_low_pin, cable_ocp_pin, cable_switch_closed, sink_start} = 5'h00;
    {auto_discharge_on_disconnect, auto_discharge_active, force_discharge_enable} = 3'h0;
    {tx_request, tx_buffer_empty} = 2'h0;
    cable_present_pin = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PDF_ADDR_FAULT, PDF_FAULT_RST);
    rd_chk(PDF_ADDR_COMMAND, PDF_COMMAND_RST);
    check({6'h00, presence_monitor_active, sinking_flag}, 8'h00);
    t_tx_cable;
    t_cmds;
    t_discharge;
    close_out;
  end
endmodule
`default_nettype wire
